// >>> bench/fsrb_bank_assertions.sv
// Concurrent checks on the status register bank ports
`timescale 1ns/1ps
`default_nettype none
module fsrb_bank_checker (
   input wire logic       sys_clk,
   input wire logic       reset_n,
   input wire logic       cmd_valid,
   input wire logic [3:0] cmd_code,
   input wire logic       write_protect_n,
   input wire logic       cmd_accept,
   input wire logic       cmd_ignored,
   input wire logic [7:0] status_protect_register,
   input wire logic [7:0] status_lock_quad_register,
   input wire logic [7:0] pin_drive_config_register,
   input wire logic       busy,
   input wire logic       write_enable_latch,
   input wire logic       array_write_start,
   input wire logic       quad_enable,
   input wire logic       hold_pin_active,
   input wire logic       reset_pin_active,
   input wire logic       write_protect_active,
   input wire logic [6:0] drive_percent
);
   wire logic [7:0] sr1 = status_protect_register;
   wire logic [7:0] sr2 = status_lock_quad_register;
   wire logic [7:0] sr3 = pin_drive_config_register;
   wire logic       rd  = (cmd_code == fsrb_pkg::FSRB_CMD_READ_SR);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Busy image one cycle later reveals the busy state at the taking edge
   a_busy_ignores: assert property (cmd_valid && !rd ##1 busy |-> cmd_ignored && !cmd_accept)
      else $error("command taken while busy");
   a_read_taken: assert property (cmd_valid && rd |=> cmd_accept && !cmd_ignored)
      else $error("status read not accepted");
   a_idle_accepts: assert property (cmd_valid && cmd_code != 4'h0 ##1 !busy |-> cmd_accept)
      else $error("command dropped while ready");
   a_busy_image: assert property (busy == sr1[0])
      else $error("busy bit differs from busy");
   a_latch_image: assert property (write_enable_latch == sr1[1])
      else $error("latch bit differs from latch");
   a_busy_drops_latch: assert property ($rose(busy) |-> !write_enable_latch)
      else $error("latch still set when operation starts");
   a_start_then_busy: assert property (array_write_start |-> ##[0:3] busy)
      else $error("array operation started without busy");
   a_reserved_zero: assert property (sr2[2] == 1'b0 && sr2[0] == 1'b0 && sr3[3:0] == 4'h0)
      else $error("reserved bit reads nonzero");
   a_drive_map: assert property ($past(reset_n, 2) |-> drive_percent == (sr3[6:5] == 2'h0 ?
      7'h32 : sr3[6:5] == 2'h1 ? 7'h19 : sr3[6:5] == 2'h2 ? 7'h4B : 7'h64))
      else $error("drive percent wrong for code");
   a_pin_roles: assert property ($past(reset_n, 2) |-> hold_pin_active == (!quad_enable && !sr3[7])
      && reset_pin_active == (!quad_enable && sr3[7]))
      else $error("pin function wrong");
   a_wp_lock: assert property ($past(reset_n, 2) |->
      write_protect_active == (sr1[7] && !quad_enable && !$past(write_protect_n)))
      else $error("write protect lock wrong");
endmodule // fsrb_bank_checker
bind fsrb_bank fsrb_bank_checker fsrb_bank_checker_i (.sys_clk, .reset_n, .cmd_valid, .cmd_code,
   .write_protect_n, .cmd_accept, .cmd_ignored, .status_protect_register,
   .status_lock_quad_register, .pin_drive_config_register, .busy, .write_enable_latch,
   .array_write_start, .quad_enable, .hold_pin_active, .reset_pin_active,
   .write_protect_active, .drive_percent);
`default_nettype wire

// >>> bench/fsrb_bank_tb_top.sv
// Self-checking testbench for the status register bank
`timescale 1ns/1ps
`default_nettype none
module fsrb_bank_tb_top;
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       write_protect_n = 1'b1;
   logic       cmd_valid, cmd_accept, cmd_ignored, busy, write_enable_latch;
   logic [3:0] cmd_code;
   logic [1:0] cmd_sel;
   logic [7:0] cmd_wdata, sr1, sr2, sr3;
   logic       array_write_start, sector_granularity, protect_direction, complement_map;
   logic [2:0] protect_field, security_lock;
   logic       quad_enable, hold_pin_active, reset_pin_active, write_protect_active;
   logic       high_frequency_mode, ack_seen, ign_seen;
   logic [6:0] drive_percent;
   logic [7:0] pct [4] = '{8'h32, 8'h19, 8'h4B, 8'h64};
   int         fail_count = 0;
   int         total_checks = 0;
   int         starts = 0;
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (array_write_start === 1'b1) starts <= starts + 1;
   fsrb_bank fsrb_bank_i (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
      .write_protect_n(write_protect_n), .cmd_accept(cmd_accept), .cmd_ignored(cmd_ignored),
      .status_protect_register(sr1), .status_lock_quad_register(sr2),
      .pin_drive_config_register(sr3), .busy(busy), .write_enable_latch(write_enable_latch),
      .array_write_start(array_write_start), .sector_granularity(sector_granularity),
      .protect_direction(protect_direction), .protect_field(protect_field),
      .complement_map(complement_map), .security_lock(security_lock),
      .quad_enable(quad_enable), .hold_pin_active(hold_pin_active),
      .reset_pin_active(reset_pin_active), .write_protect_active(write_protect_active),
      .drive_percent(drive_percent), .high_frequency_mode(high_frequency_mode));
   fsrb_host_model fsrb_host_model_i (.sys_clk(sys_clk), .cmd_accept(cmd_accept),
      .cmd_ignored(cmd_ignored), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic do_cmd(input logic [3:0] c, input logic [1:0] s, input logic [7:0] d);
      fsrb_host_model_i.send(c, s, d, ack_seen, ign_seen);
   endtask
   // Waits out an embedded operation of up to 3000 cycles, then lets the register images settle
   task automatic idle;
      int n;
      n = 0;
      repeat (3) @(negedge sys_clk);
      while (busy !== 1'b0 && n < 3000) begin
         @(negedge sys_clk);
         n++;
      end
      chk("busy wait", 8'h00, {7'h00, busy});
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic wr(input logic vol, input logic [1:0] s, input logic [7:0] d);
      if (vol) do_cmd(fsrb_pkg::FSRB_CMD_WREN_VOL, 2'h0, 8'h00);
      else do_cmd(fsrb_pkg::FSRB_CMD_WREN, 2'h0, 8'h00);
      do_cmd(fsrb_pkg::FSRB_CMD_WRSR, s, d);
      idle();
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk("sr1", 8'h00, sr1);
      chk("sr2", 8'h00, sr2);
      chk("sr3", 8'h00, sr3);
      do_cmd(fsrb_pkg::FSRB_CMD_WREN, 2'h0, 8'h00);
      repeat (2) @(negedge sys_clk);
      chk("latch", 8'h01, {7'h00, write_enable_latch});
      do_cmd(fsrb_pkg::FSRB_CMD_WRDI, 2'h0, 8'h00);
      repeat (2) @(negedge sys_clk);
      chk("latch", 8'h00, {7'h00, write_enable_latch});
      do_cmd(fsrb_pkg::FSRB_CMD_WRSR, fsrb_pkg::SEL_STATUS_PROTECT, 8'h1C);
      idle();
      chk("sr1 no latch", 8'h00, sr1);
      do_cmd(fsrb_pkg::FSRB_CMD_WREN, 2'h0, 8'h00);
      do_cmd(fsrb_pkg::FSRB_CMD_WRSR, fsrb_pkg::SEL_STATUS_PROTECT, 8'h7F);
      repeat (3) @(negedge sys_clk);
      chk("sr1 busy", 8'h01, sr1);
      do_cmd(fsrb_pkg::FSRB_CMD_WREN, 2'h0, 8'h00);
      chk("ignored", 8'h01, {7'h00, ign_seen});
      do_cmd(fsrb_pkg::FSRB_CMD_READ_SR, 2'h0, 8'h00);
      chk("read accepted", 8'h01, {7'h00, ack_seen});
      idle();
      chk("sr1", 8'h7C, sr1);
      chk("fields", 8'h1F, {3'h0, sector_granularity, protect_direction, protect_field});
      wr(1'b0, fsrb_pkg::SEL_STATUS_PROTECT, 8'h80);
      write_protect_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("wp lock", 8'h01, {7'h00, write_protect_active});
      wr(1'b0, fsrb_pkg::SEL_STATUS_PROTECT, 8'h00);
      chk("sr1 locked", 8'h80, sr1);
      wr(1'b0, fsrb_pkg::SEL_LOCK_QUAD, 8'h40);
      chk("sr2 locked", 8'h00, sr2);
      write_protect_n = 1'b1;
      wr(1'b0, fsrb_pkg::SEL_STATUS_PROTECT, 8'h00);
      chk("sr1 unlocked", 8'h00, sr1);
      wr(1'b0, fsrb_pkg::SEL_LOCK_QUAD, 8'hFF);
      chk("sr2", 8'h7A, sr2);
      chk("quad", 8'h7C, {1'b0, quad_enable, complement_map, security_lock,
         hold_pin_active, reset_pin_active});
      wr(1'b0, fsrb_pkg::SEL_LOCK_QUAD, 8'h00);
      chk("sr2 otp", 8'h38, sr2);
      for (int d = 0; d < 4; d++) begin
         wr(1'b1, fsrb_pkg::SEL_PIN_DRIVE, {1'b1, d[1:0], 5'h1F});
         chk("sr3", {1'b1, d[1:0], 5'h10}, sr3);
         chk("drive", pct[d], {1'b0, drive_percent});
         chk("pins", 8'h03, {6'h00, reset_pin_active, high_frequency_mode});
      end
      wr(1'b1, fsrb_pkg::SEL_PIN_DRIVE, 8'h00);
      chk("hold", 8'h02, {6'h00, hold_pin_active, high_frequency_mode});
      do_cmd(fsrb_pkg::FSRB_CMD_SUSPEND, 2'h0, 8'h00);
      repeat (2) @(negedge sys_clk);
      chk("suspend", 8'hB8, sr2);
      wr(1'b1, fsrb_pkg::SEL_LOCK_QUAD, 8'h00);
      chk("suspend kept", 8'hB8, sr2);
      do_cmd(fsrb_pkg::FSRB_CMD_RESUME, 2'h0, 8'h00);
      repeat (2) @(negedge sys_clk);
      chk("resume", 8'h38, sr2);
      wr(1'b1, fsrb_pkg::SEL_STATUS_PROTECT, 8'h3C);
      chk("sr1 vol", 8'h3C, sr1);
      do_cmd(fsrb_pkg::FSRB_CMD_SW_RESET, 2'h0, 8'h00);
      idle();
      chk("sr1 reload", 8'h00, sr1);
      chk("sr2 reload", 8'h38, sr2);
      do_cmd(fsrb_pkg::FSRB_CMD_ERASE, 2'h0, 8'h00);
      do_cmd(fsrb_pkg::FSRB_CMD_PROGRAM, 2'h0, 8'h00);
      chk("prog taken", 8'h01, {7'h00, ack_seen});
      idle();
      chk("no start", 8'h00, starts[7:0]);
      do_cmd(fsrb_pkg::FSRB_CMD_WREN, 2'h0, 8'h00);
      do_cmd(fsrb_pkg::FSRB_CMD_ERASE, 2'h0, 8'h00);
      repeat (3) @(negedge sys_clk);
      chk("erase busy", 8'h01, sr1);
      idle();
      chk("start", 8'h01, starts[7:0]);
      chk("sr1 done", 8'h00, sr1);
      tally_and_finish();
   end
endmodule // fsrb_bank_tb_top
`default_nettype wire

// >>> bench/fsrb_host_model.sv
// Host side model presenting decoded instructions to the bank
`timescale 1ns/1ps
`default_nettype none
module fsrb_host_model (
   input  wire logic       sys_clk,
   input  wire logic       cmd_accept,
   input  wire logic       cmd_ignored,
   output logic            cmd_valid,
   output logic [3:0]      cmd_code,
   output logic [1:0]      cmd_sel,
   output logic [7:0]      cmd_wdata
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = 4'h0;
      cmd_sel   = 2'h0;
      cmd_wdata = 8'h00;
   end
   // One-cycle pulse; the answer is read half a cycle after the taking edge
   task automatic send(input logic [3:0] c, input logic [1:0] s, input logic [7:0] d,
                       output logic ack, output logic ign);
      @(negedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_code  <= c;
      cmd_sel   <= s;
      cmd_wdata <= d;
      @(negedge sys_clk);
      cmd_valid <= 1'b0;
      cmd_wdata <= ~d;
      ack = cmd_accept;
      ign = cmd_ignored;
   endtask
endmodule // fsrb_host_model
`default_nettype wire

// >>> rtl/fsrb_bank.sv
// Flash status register bank: status, protection and pin configuration
//
// Functional notes
// - Busy set during program, erase, status write
// - While busy, only status reads accepted
// - Busy clears when operation finishes
// - Write enable instruction sets the latch
// - Latch cleared by reset, disable, embedded ops
// - No program or erase without the latch; status write needs latch or volatile enable
// - Bit 6 selects sector or block granularity
// - Bit 5 selects top or bottom protection
// - Bit 7 lets write-protect pin lock registers
// - Second register bit 7 reports suspend
// - Second register bit 6 selects complement map
// - OTP lock bits protect security registers
// - Quad enable turns protect pins into data
// - Third register bit 7 picks hold or reset
// - Third register bits 6:5 set drive strength
// - Third register bit 4 enables high frequency
// - Non-volatile and volatile copies, default zero
// - Power-up or soft reset loads volatile copies
// - Volatile enable steers next write to volatile
// - Protect mode with pin low and quad off blocks first and second register writes
`timescale 1ns/1ps
`default_nettype none
module fsrb_bank (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        cmd_valid,
   input  wire logic [3:0]  cmd_code,
   input  wire logic [1:0]  cmd_sel,
   input  wire logic [7:0]  cmd_wdata,
   input  wire logic        write_protect_n,
   output logic             cmd_accept,
   output logic             cmd_ignored,
   output logic [7:0]       status_protect_register,
   output logic [7:0]       status_lock_quad_register,
   output logic [7:0]       pin_drive_config_register,
   output logic             busy,
   output logic             write_enable_latch,
   output logic             array_write_start,
   output logic             sector_granularity,
   output logic             protect_direction,
   output logic [2:0]       protect_field,
   output logic             complement_map,
   output logic [2:0]       security_lock,
   output logic             quad_enable,
   output logic             hold_pin_active,
   output logic             reset_pin_active,
   output logic             write_protect_active,
   output logic [6:0]       drive_percent,
   output logic             high_frequency_mode
);

   fsrb_nv_if nv ();

   fsrb_nv_store u_store (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .nv      (nv)
   );

   fsrb_pkg::fsrb_state_e                state_q;
   logic [fsrb_pkg::CNT_W-1:0]           cnt_q;
   logic                                 busy_q;
   logic                                 wel_q;
   logic                                 vol_en_q;
   logic                                 sus_q;
   logic                                 load_q;
   logic [7:0]                           vol_sr1_q;
   logic [7:0]                           vol_sr2_q;
   logic [7:0]                           vol_sr3_q;
   logic                                 pend_vld_q;
   logic                                 pend_nv_q;
   logic [1:0]                           pend_sel_q;
   logic [7:0]                           pend_data_q;
   logic                                 take;
   logic                                 sr_locked;
   logic                                 wr_ok;
   logic                                 start_op;
   logic [fsrb_pkg::CNT_W-1:0]           op_len;
   fsrb_pkg::fsrb_cmd_e                  cmd;

   assign cmd = fsrb_pkg::fsrb_cmd_e'(cmd_code);

   // Instructions other than status read are dropped while busy
   assign take = cmd_valid && (!busy_q || cmd == fsrb_pkg::FSRB_CMD_READ_SR);

   // Pin lock only when protect mode set, pin low and quad off
   assign sr_locked = vol_sr1_q[fsrb_pkg::BIT_PROT_MODE] && !write_protect_n
                      && !vol_sr2_q[fsrb_pkg::BIT_QUAD];

   // Third register is not covered by the pin lock
   assign wr_ok = (cmd_sel == fsrb_pkg::SEL_PIN_DRIVE) || !sr_locked;

   // Operations that need the latch or the volatile enable
   always_comb begin
      start_op = 1'b0;
      op_len   = '0;
      if (take) begin
         case (cmd)
            fsrb_pkg::FSRB_CMD_PROGRAM: begin
               start_op = wel_q;
               op_len   = fsrb_pkg::CNT_W'(fsrb_pkg::PROGRAM_CYC);
            end
            fsrb_pkg::FSRB_CMD_ERASE: begin
               start_op = wel_q;
               op_len   = fsrb_pkg::CNT_W'(fsrb_pkg::ERASE_CYC);
            end
            fsrb_pkg::FSRB_CMD_WRSR: begin
               start_op = (wel_q || vol_en_q) && wr_ok;
               op_len   = fsrb_pkg::CNT_W'(fsrb_pkg::STATUS_WRITE_CYC);
            end
            default: begin
               start_op = 1'b0;
               op_len   = '0;
            end
         endcase
      end
   end

   // Embedded operation sequencer
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= fsrb_pkg::FSRB_IDLE;
         cnt_q   <= '0;
         busy_q  <= 1'b0;
      end else begin
         case (state_q)
            fsrb_pkg::FSRB_IDLE: begin
               if (take && cmd == fsrb_pkg::FSRB_CMD_SW_RESET) begin
                  state_q <= fsrb_pkg::FSRB_RESET;
                  cnt_q   <= fsrb_pkg::CNT_W'(fsrb_pkg::SW_RESET_CYC - 1);
                  busy_q  <= 1'b1;
               end else if (start_op) begin
                  state_q <= fsrb_pkg::FSRB_RUN;
                  cnt_q   <= op_len - 1'b1;
                  busy_q  <= 1'b1;
               end
            end
            fsrb_pkg::FSRB_RUN, fsrb_pkg::FSRB_RESET: begin
               if (cnt_q == '0) begin
                  state_q <= fsrb_pkg::FSRB_FINISH;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            fsrb_pkg::FSRB_FINISH: begin
               state_q <= fsrb_pkg::FSRB_IDLE;
               busy_q  <= 1'b0;
            end
            default: begin
               state_q <= fsrb_pkg::FSRB_IDLE;
               busy_q  <= 1'b0;
            end
         endcase
      end
   end

   // Write enable latch
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wel_q <= 1'b0;
      end else if (take) begin
         case (cmd)
            fsrb_pkg::FSRB_CMD_WREN:     wel_q <= 1'b1;
            fsrb_pkg::FSRB_CMD_WRDI,
            fsrb_pkg::FSRB_CMD_PROGRAM,
            fsrb_pkg::FSRB_CMD_ERASE,
            fsrb_pkg::FSRB_CMD_WRSR,
            fsrb_pkg::FSRB_CMD_SW_RESET: wel_q <= 1'b0;
            default:                     wel_q <= wel_q;
         endcase
      end
   end

   // Volatile-write enable holds for the next status write only
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         vol_en_q <= 1'b0;
      end else if (take) begin
         case (cmd)
            fsrb_pkg::FSRB_CMD_WREN_VOL: vol_en_q <= 1'b1;
            fsrb_pkg::FSRB_CMD_WREN,
            fsrb_pkg::FSRB_CMD_WRDI,
            fsrb_pkg::FSRB_CMD_WRSR,
            fsrb_pkg::FSRB_CMD_SW_RESET: vol_en_q <= 1'b0;
            default:                     vol_en_q <= vol_en_q;
         endcase
      end
   end

   // Suspend flag; set by suspend, cleared by resume and software reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sus_q <= 1'b0;
      end else if (take && cmd == fsrb_pkg::FSRB_CMD_SUSPEND) begin
         sus_q <= 1'b1;
      end else if (take && (cmd == fsrb_pkg::FSRB_CMD_RESUME
                            || cmd == fsrb_pkg::FSRB_CMD_SW_RESET)) begin
         sus_q <= 1'b0;
      end
   end

   // Captured status write, committed when the operation ends
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_vld_q  <= 1'b0;
         pend_nv_q   <= 1'b0;
         pend_sel_q  <= fsrb_pkg::SEL_STATUS_PROTECT;
         pend_data_q <= 8'h00;
      end else if (start_op && cmd == fsrb_pkg::FSRB_CMD_WRSR) begin
         pend_vld_q  <= 1'b1;
         pend_nv_q   <= !vol_en_q;
         pend_sel_q  <= cmd_sel;
         pend_data_q <= cmd_wdata;
      end else if (state_q == fsrb_pkg::FSRB_FINISH) begin
         pend_vld_q  <= 1'b0;
         pend_nv_q   <= 1'b0;
      end
   end

   // Non-volatile store write at the end of a status write
   always_comb begin
      nv.wr_en   = state_q == fsrb_pkg::FSRB_FINISH && pend_nv_q;
      nv.wr_sel  = pend_sel_q;
      nv.wr_data = pend_data_q;
      case (pend_sel_q)
         fsrb_pkg::SEL_STATUS_PROTECT: nv.wr_mask = fsrb_pkg::MASK_SR1;
         fsrb_pkg::SEL_LOCK_QUAD:      nv.wr_mask = fsrb_pkg::MASK_SR2
                                                    | fsrb_pkg::MASK_SR2_LOCK;
         fsrb_pkg::SEL_PIN_DRIVE:      nv.wr_mask = fsrb_pkg::MASK_SR3_NV;
         default:                      nv.wr_mask = 8'h00;
      endcase
   end

   // Reload request after power-up and software reset
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         load_q <= 1'b1;
      end else begin
         load_q <= state_q == fsrb_pkg::FSRB_RESET && cnt_q == '0;
      end
   end

   // Volatile working copies
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         vol_sr1_q <= fsrb_pkg::RESET_VOL;
         vol_sr2_q <= fsrb_pkg::RESET_VOL;
         vol_sr3_q <= fsrb_pkg::RESET_VOL;
      end else if (load_q) begin
         vol_sr1_q <= nv.nv_sr1 & fsrb_pkg::MASK_SR1;
         vol_sr2_q <= nv.nv_sr2 & fsrb_pkg::MASK_SR2;
         vol_sr3_q <= nv.nv_sr3 & fsrb_pkg::MASK_SR3_NV;
      end else if (state_q == fsrb_pkg::FSRB_FINISH && pend_vld_q) begin
         case (pend_sel_q)
            fsrb_pkg::SEL_STATUS_PROTECT:
               vol_sr1_q <= pend_data_q & fsrb_pkg::MASK_SR1;
            fsrb_pkg::SEL_LOCK_QUAD:
               vol_sr2_q <= pend_data_q & fsrb_pkg::MASK_SR2;
            fsrb_pkg::SEL_PIN_DRIVE:
               vol_sr3_q <= pend_data_q & (pend_nv_q ? fsrb_pkg::MASK_SR3_NV
                                                     : fsrb_pkg::MASK_SR3_VOL);
            default:
               vol_sr3_q <= vol_sr3_q;
         endcase
      end
   end

   // Command handshake outputs
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_accept        <= 1'b0;
         cmd_ignored       <= 1'b0;
         array_write_start <= 1'b0;
      end else begin
         cmd_accept        <= take;
         cmd_ignored       <= cmd_valid && !take;
         array_write_start <= start_op && cmd != fsrb_pkg::FSRB_CMD_WRSR;
      end
   end

   // Register images and decoded controls
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_protect_register   <= 8'h00;
         status_lock_quad_register <= 8'h00;
         pin_drive_config_register <= 8'h00;
         busy                      <= 1'b0;
         write_enable_latch        <= 1'b0;
         sector_granularity        <= 1'b0;
         protect_direction         <= 1'b0;
         protect_field             <= 3'h0;
         complement_map            <= 1'b0;
         security_lock             <= 3'h0;
         quad_enable               <= 1'b0;
         hold_pin_active           <= 1'b0;
         reset_pin_active          <= 1'b0;
         write_protect_active      <= 1'b0;
         drive_percent             <= 7'h00;
         high_frequency_mode       <= 1'b0;
      end else begin
         status_protect_register   <= vol_sr1_q | {6'h00, wel_q, busy_q};
         status_lock_quad_register <= vol_sr2_q | (nv.nv_sr2 & fsrb_pkg::MASK_SR2_LOCK)
                                      | {sus_q, 7'h00};
         pin_drive_config_register <= vol_sr3_q;

         // Status levels
         busy                      <= busy_q;
         write_enable_latch        <= wel_q;

         // Protection fields
         sector_granularity        <= vol_sr1_q[fsrb_pkg::BIT_SECTOR];
         protect_direction         <= vol_sr1_q[fsrb_pkg::BIT_DIRECTION];
         protect_field             <= vol_sr1_q[fsrb_pkg::BIT_PROT_LO +: 3];
         complement_map            <= vol_sr2_q[fsrb_pkg::BIT_COMPLEMENT];
         security_lock             <= nv.nv_sr2[fsrb_pkg::BIT_LOCK_LO +: 3];
         quad_enable               <= vol_sr2_q[fsrb_pkg::BIT_QUAD];

         // Pin roles
         hold_pin_active           <= !vol_sr2_q[fsrb_pkg::BIT_QUAD]
                                      && !vol_sr3_q[fsrb_pkg::BIT_HOLD_RESET];
         reset_pin_active          <= !vol_sr2_q[fsrb_pkg::BIT_QUAD]
                                      && vol_sr3_q[fsrb_pkg::BIT_HOLD_RESET];
         write_protect_active      <= sr_locked;

         // Drive strength
         case (vol_sr3_q[fsrb_pkg::BIT_DRIVE_LO +: 2])
            2'h0:    drive_percent <= 7'h32;
            2'h1:    drive_percent <= 7'h19;
            2'h2:    drive_percent <= 7'h4B;
            default: drive_percent <= 7'h64;
         endcase

         // Frequency mode
         high_frequency_mode       <= vol_sr3_q[fsrb_pkg::BIT_FREQ];
      end
   end

endmodule // fsrb_bank
`default_nettype wire

// >>> rtl/fsrb_nv_if.sv
// Interface carrying the non-volatile store port between bank and store
`timescale 1ns/1ps
`default_nettype none
interface fsrb_nv_if;
   logic       wr_en;
   logic [1:0] wr_sel;
   logic [7:0] wr_data;
   logic [7:0] wr_mask;
   logic [7:0] nv_sr1;
   logic [7:0] nv_sr2;
   logic [7:0] nv_sr3;
   modport bank  (output wr_en, wr_sel, wr_data, wr_mask, input nv_sr1, nv_sr2, nv_sr3);
   modport store (input wr_en, wr_sel, wr_data, wr_mask, output nv_sr1, nv_sr2, nv_sr3);
endinterface
`default_nettype wire

// >>> rtl/fsrb_nv_store.sv
// Non-volatile copies of the status register bits
`timescale 1ns/1ps
`default_nettype none
module fsrb_nv_store (
   input wire logic  sys_clk,
   input wire logic  reset_n,
   fsrb_nv_if.store  nv
);
   logic [7:0] nv_q [3];

   // Masked write; lock bits may only go from 0 to 1
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_reg
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               nv_q[g] <= fsrb_pkg::RESET_NV;
            end else if (nv.wr_en && nv.wr_sel == 2'(g)) begin
               nv_q[g] <= (nv_q[g] & ~nv.wr_mask) | (nv.wr_data & nv.wr_mask)
                          | (g == 1 ? (nv_q[g] & fsrb_pkg::MASK_SR2_LOCK) : 8'h00);
            end
         end
      end
   endgenerate

   assign nv.nv_sr1 = nv_q[0];
   assign nv.nv_sr2 = nv_q[1];
   assign nv.nv_sr3 = nv_q[2];
endmodule // fsrb_nv_store
`default_nettype wire

// >>> rtl/fsrb_pkg.sv
// Package of constants and types for the flash status register bank
`default_nettype none
package fsrb_pkg;

   // Register selectors on the command port
   localparam logic [1:0] SEL_STATUS_PROTECT = 2'h0;
   localparam logic [1:0] SEL_LOCK_QUAD      = 2'h1;
   localparam logic [1:0] SEL_PIN_DRIVE      = 2'h2;

   // First register field positions
   localparam int BIT_BUSY        = 0;
   localparam int BIT_WEL         = 1;
   localparam int BIT_PROT_LO     = 2;
   localparam int BIT_DIRECTION   = 5;
   localparam int BIT_SECTOR      = 6;
   localparam int BIT_PROT_MODE   = 7;
   // Second register field positions
   localparam int BIT_QUAD        = 1;
   localparam int BIT_LOCK_LO     = 3;
   localparam int BIT_COMPLEMENT  = 6;
   localparam int BIT_SUSPEND     = 7;
   // Third register field positions
   localparam int BIT_FREQ        = 4;
   localparam int BIT_DRIVE_LO    = 5;
   localparam int BIT_HOLD_RESET  = 7;

   // Writable masks (reserved and read-only bits excluded)
   localparam logic [7:0] MASK_SR1      = 8'hFC;
   localparam logic [7:0] MASK_SR2      = 8'h42;
   localparam logic [7:0] MASK_SR2_LOCK = 8'h38;
   localparam logic [7:0] MASK_SR3_NV   = 8'h90;
   localparam logic [7:0] MASK_SR3_VOL  = 8'hF0;

   // Reset values
   localparam logic [7:0] RESET_NV      = 8'h00;
   localparam logic [7:0] RESET_VOL     = 8'h00;

   // Embedded operation times
   localparam int CLK_MHZ           = 100;
   localparam int STATUS_WRITE_US   = 5;
   localparam int PROGRAM_US        = 700;
   localparam int ERASE_US          = 20;
   localparam int SW_RESET_US       = 10;
   localparam int STATUS_WRITE_CYC  = STATUS_WRITE_US * CLK_MHZ;
   localparam int SW_RESET_CYC      = SW_RESET_US * CLK_MHZ;
   localparam int PROGRAM_CYC       = PROGRAM_US * CLK_MHZ;
   localparam int ERASE_CYC         = ERASE_US * CLK_MHZ;
   localparam int CNT_W             = 24;

   // Decoded instructions from the command decoder
   typedef enum logic [3:0] {
      FSRB_CMD_NONE      = 4'h0,
      FSRB_CMD_WREN      = 4'h1,
      FSRB_CMD_WRDI      = 4'h2,
      FSRB_CMD_WREN_VOL  = 4'h3,
      FSRB_CMD_WRSR      = 4'h4,
      FSRB_CMD_READ_SR   = 4'h5,
      FSRB_CMD_PROGRAM   = 4'h6,
      FSRB_CMD_ERASE     = 4'h7,
      FSRB_CMD_SUSPEND   = 4'h8,
      FSRB_CMD_RESUME    = 4'h9,
      FSRB_CMD_SW_RESET  = 4'hA
   } fsrb_cmd_e;

   // Embedded operation states, Gray coded along idle-run-finish
   typedef enum logic [1:0] {
      FSRB_IDLE   = 2'b00,
      FSRB_RUN    = 2'b01,
      FSRB_FINISH = 2'b11,
      FSRB_RESET  = 2'b10
   } fsrb_state_e;

endpackage

`default_nettype wire
